// >>> bench/ffmd_detector_checker.sv
// Port-level assertions for the freefall/motion detector
`default_nettype none
module ffmd_detector_checker
(
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic [7:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] o_reg_rdata,
   input wire logic i_sample_valid,
   input wire logic o_event_active,
   input wire logic o_irq_line1,
   input wire logic o_irq_line2
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   sequence rd_src;
      i_reg_rd && i_reg_addr == 8'h16;
   endsequence
   sequence rd_cfg;
      i_reg_rd && i_reg_addr == 8'h15;
   endsequence
   cfg_low_zero_a: assert property (rd_cfg |=> o_reg_rdata[2:0] == 3'h0)
      else $error("config low bits not zero");
   src_bit6_a: assert property (rd_src |=> o_reg_rdata[6] == 1'b0)
      else $error("source bit 6 not zero");
   ea_copy_a: assert property (rd_src |=>
      o_reg_rdata[7] == $past(o_event_active))
      else $error("source bit 7 differs from event flag");
   sign_flag_a: assert property (rd_src |=>
      ((o_reg_rdata & ~(o_reg_rdata >> 1)) & 8'h15) == 8'h00)
      else $error("sign bit set without its flag");
   ea_rise_a: assert property ($rose(o_event_active) |->
      $past(i_sample_valid))
      else $error("event flag rose without a sample");
   // A write that turns every axis off clears the flag two cycles later
   ea_fall_a: assert property ($fell(o_event_active) |->
      $past(i_sample_valid || i_reg_rd || !i_reset_n)
      || $past(i_reg_wr, 2))
      else $error("event flag fell without a cause");
   irq_gate_a: assert property (o_irq_line1 || o_irq_line2 |->
      o_event_active)
      else $error("interrupt without event");
   irq_excl_a: assert property (!(o_irq_line1 && o_irq_line2))
      else $error("both interrupt lines high");
   reset_clear_a: assert property ($rose(i_reset_n) |->
      !o_event_active && o_reg_rdata == 8'h00 && !o_irq_line1
      && !o_irq_line2)
      else $error("outputs not cleared by reset");
endmodule // ffmd_detector_checker
bind ffmd_detector ffmd_detector_checker u_chk (.i_clk(i_clk),
   .i_reset_n(i_reset_n), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
   .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
   .i_sample_valid(i_sample_valid), .o_event_active(o_event_active),
   .o_irq_line1(o_irq_line1), .o_irq_line2(o_irq_line2));
`default_nettype wire

// >>> bench/ffmd_detector_tb_top.sv
// Self-checking bench of the freefall/motion detector
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin errors++; \
   $display("FAIL t=%0t got=%h exp=%h", $time, a, e); end end
module ffmd_detector_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk = 0, i_reset_n = 0, rd = 0, wr = 0, sv = 0;
   logic [7:0] addr = 8'h00, wd = 8'h00, x = 8'h00, y = 8'h00, z = 8'h00;
   logic [6:0] thr = 7'h0A;
   logic lmode = 1, ien = 0, iroute = 0;
   logic [7:0] tgt = 8'h00, rdat, cfg;
   wire [7:0] o_rdata;
   wire o_ea, o_irq1, o_irq2;
   int errors = 0, num_checks = 0, cycles = 0;
   // cfg, threshold, x, y, z, expected source
   logic [47:0] rows [9] = '{48'h480A14000082, 48'h480AF5000083,
      48'h480A0A000000, 48'h780A00F00BAC, 48'h380A0AF60080,
      48'h380A0B000002, 48'h180A00006480, 48'h400A64000000,
      48'h507F0080008C};
   ffmd_detector DUT (.i_clk(i_clk), .i_reset_n(i_reset_n),
      .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wd), .i_reg_rd(rd),
      .o_reg_rdata(o_rdata), .i_sample_valid(sv), .i_x_sample(x),
      .i_y_sample(y), .i_z_sample(z), .i_detect_threshold(thr),
      .i_debounce_lapse_mode(lmode), .i_debounce_target(tgt),
      .i_detect_irq_enable(ien), .i_detect_irq_route(iroute),
      .o_event_active(o_ea), .o_irq_line1(o_irq1), .o_irq_line2(o_irq2));
   always #20 i_clk = ~i_clk;
   // Strobes drop for a full cycle so no strobe is set twice in one step
   task automatic cyc(input logic r, w, s, input logic [7:0] a, d);
      rd = r;
      wr = w;
      sv = s;
      addr = a;
      wd = d;
      @(posedge i_clk) #1;
      rd = 0;
      wr = 0;
      sv = 0;
      rdat = o_rdata;
      @(posedge i_clk) #1;
   endtask
   task automatic smp(input logic [7:0] xv);
      x = xv;
      cyc(0, 0, 1, 8'h00, 8'h00);
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge i_clk)
   begin
      cycles++;
      if (cycles == 1000)
      begin
         errors++;
         end_of_test;
      end
   end
   initial
   begin
      repeat (10) @(posedge i_clk);
      #1 i_reset_n = 1;
      cyc(1, 0, 0, 8'h15, 8'h00);
      `CHK(rdat, 8'h00)
      cyc(1, 0, 0, 8'h16, 8'h00);
      `CHK(rdat, 8'h00)
      cyc(1, 0, 0, 8'h20, 8'h00);
      `CHK(rdat, 8'h00)
      $display("reset test done");
      foreach (rows[i])
      begin
         cfg = rows[i][47:40];
         thr = rows[i][38:32];
         {x, y, z} = rows[i][31:8];
         cyc(0, 1, 0, 8'h15, cfg | 8'h07);
         cyc(1, 0, 0, 8'h15, 8'h00);
         `CHK(rdat, cfg)
         cyc(0, 0, 1, 8'h00, 8'h00);
         cyc(1, 0, 0, 8'h16, 8'h00);
         `CHK(rdat, rows[i][7:0])
         `CHK(o_irq1 | o_irq2, 1'b0)
      end
      $display("table test done");
      // Latched motion on X, target 3, decrement on lapse
      {y, z, thr, tgt, lmode, ien, iroute} = {16'h0000, 7'h0A, 8'h03, 3'b011};
      cyc(0, 1, 0, 8'h15, 8'hC8);
      // Event left over from the table must be read away first
      cyc(1, 0, 0, 8'h16, 8'h00);
      `CHK(rdat, 8'h80)
      foreach (rows[i])
      begin
         if (i < 5)
         begin
            smp(i == 2 ? 8'h00 : 8'h14);
            `CHK(o_ea, i == 4)
         end
      end
      `CHK(o_irq1, 1'b1)
      smp(8'hEC);
      smp(8'h00);
      `CHK(o_ea, 1'b1)
      cyc(1, 0, 0, 8'h16, 8'h00);
      `CHK(rdat, 8'h82)
      `CHK(o_ea, 1'b0)
      cyc(1, 0, 0, 8'h16, 8'h00);
      `CHK(rdat, 8'h00)
      smp(8'h14);
      `CHK(o_ea, 1'b0)
      cyc(1, 0, 0, 8'h16, 8'h00);
      `CHK(rdat, 8'h02)
      $display("latched test done");
      // Live motion on X, target 2, clear on lapse
      {tgt, lmode, iroute} = {8'h02, 2'b10};
      cyc(0, 1, 0, 8'h15, 8'h48);
      smp(8'h00);
      smp(8'h14);
      smp(8'h14);
      `CHK(o_irq2, 1'b1)
      cyc(1, 0, 0, 8'h16, 8'h00);
      cyc(1, 0, 0, 8'h16, 8'h00);
      `CHK(rdat, 8'h82)
      `CHK(o_ea, 1'b1)
      smp(8'h00);
      `CHK(o_ea, 1'b0)
      $display("live test done");
      // Reset in mid-run while an event and its interrupt stand
      smp(8'h14);
      smp(8'h14);
      `CHK(o_irq2, 1'b1)
      i_reset_n = 0;
      @(posedge i_clk) #1;
      i_reset_n = 1;
      `CHK(o_ea | o_irq1 | o_irq2, 1'b0)
      cyc(1, 0, 0, 8'h15, 8'h00);
      `CHK(rdat, 8'h00)
      cyc(1, 0, 0, 8'h16, 8'h00);
      `CHK(rdat, 8'h00)
      $display("mid-run reset test done");
      end_of_test;
   end
endmodule // ffmd_detector_tb_top
`default_nettype wire

// >>> hdl/ffmd_axis_cmp.v
// One-axis magnitude comparator against the shared 7-bit threshold
`default_nettype none

module ffmd_axis_cmp
(
   input wire [7:0] i_sample,
   input wire [6:0] i_threshold,
   output wire o_over,
   output wire o_under,
   output wire o_negative
);

   wire [7:0] magnitude;
   wire [7:0] ths_wide;

   // -128 gives 128, which still exceeds any 7-bit threshold
   assign magnitude = i_sample[7] ? (~i_sample + 8'h01) : i_sample;
   assign ths_wide = {1'b0, i_threshold};
   assign o_over = (magnitude > ths_wide);
   assign o_under = ~o_over;
   assign o_negative = i_sample[7];

endmodule // ffmd_axis_cmp

`default_nettype wire

// >>> hdl/ffmd_defs.vh
// Register map, field positions and reset values of the freefall/motion unit
`ifndef FFMD_DEFS_VH
`define FFMD_DEFS_VH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define FFMD_ADDR_CONFIG 8'h15
`define FFMD_ADDR_SOURCE 8'h16

// ------------------------------------------------------------
// Configuration register fields
// ------------------------------------------------------------
`define FFMD_CFG_LATCH 7
`define FFMD_CFG_OR_AND 6
`define FFMD_CFG_Z_EN 5
`define FFMD_CFG_Y_EN 4
`define FFMD_CFG_X_EN 3
`define FFMD_CFG_STORED_MASK 8'hF8

// ------------------------------------------------------------
// Source register fields
// ------------------------------------------------------------
`define FFMD_SRC_EA 7
`define FFMD_SRC_ZERO 6
`define FFMD_SRC_Z_FLAG 5
`define FFMD_SRC_Z_SIGN 4
`define FFMD_SRC_Y_FLAG 3
`define FFMD_SRC_Y_SIGN 2
`define FFMD_SRC_X_FLAG 1
`define FFMD_SRC_X_SIGN 0

// ------------------------------------------------------------
// Reset values and constants
// ------------------------------------------------------------
`define FFMD_CONFIG_RESET 8'h00
`define FFMD_FLAGS_RESET 6'h00
`define FFMD_COUNT_RESET 8'h00
`define FFMD_RDATA_UNMAPPED 8'h00
`define FFMD_COUNT_ONE 8'h01
// Threshold weight, milli-g per count
`define FFMD_THS_MILLI_G_PER_LSB 63

`endif

// >>> hdl/ffmd_detector.v
// Freefall/motion detector: configuration, debounce and source register
`include "ffmd_defs.vh"
`default_nettype none

module ffmd_detector
(
   input wire i_clk,
   input wire i_reset_n,
   input wire [7:0] i_reg_addr,
   input wire i_reg_wr,
   input wire [7:0] i_reg_wdata,
   input wire i_reg_rd,
   output reg [7:0] o_reg_rdata,
   input wire i_sample_valid,
   input wire [7:0] i_x_sample,
   input wire [7:0] i_y_sample,
   input wire [7:0] i_z_sample,
   input wire [6:0] i_detect_threshold,
   input wire i_debounce_lapse_mode,
   input wire [7:0] i_debounce_target,
   input wire i_detect_irq_enable,
   input wire i_detect_irq_route,
   output reg o_event_active,
   output reg o_irq_line1,
   output reg o_irq_line2
);

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function [7:0] ffmd_step_down;
      input [7:0] value;
      begin
         ffmd_step_down = (value == `FFMD_COUNT_RESET) ? `FFMD_COUNT_RESET
            : (value - `FFMD_COUNT_ONE);
      end
   endfunction

   // Register select, used by both strobes
   function ffmd_addr_hit;
      input [7:0] addr;
      input [7:0] offset;
      begin
         ffmd_addr_hit = (addr == offset);
      end
   endfunction

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   reg [7:0] detect_config_reg;
   reg event_active;
   reg [5:0] axis_flags;
   reg [7:0] debounce_count;

   reg [7:0] next_count;
   reg next_active;
   reg [5:0] next_flags;

   wire latch_events;
   wire or_and_select;
   wire z_axis_enable;
   wire y_axis_enable;
   wire x_axis_enable;
   wire any_enable;
   wire x_over;
   wire x_under;
   wire x_neg;
   wire y_over;
   wire y_under;
   wire y_neg;
   wire z_over;
   wire z_under;
   wire z_neg;
   wire motion_cond;
   wire freefall_cond;
   wire condition;
   wire src_read;
   wire cfg_write;
   wire [5:0] live_flags;
   wire [5:0] enable_mask;
   wire [7:0] detect_source_reg;
   wire [7:0] base_count;
   wire src_hit;
   wire cfg_hit;
   wire next_irq1;
   wire next_irq2;

   assign latch_events = detect_config_reg[`FFMD_CFG_LATCH];
   assign or_and_select = detect_config_reg[`FFMD_CFG_OR_AND];
   assign z_axis_enable = detect_config_reg[`FFMD_CFG_Z_EN];
   assign y_axis_enable = detect_config_reg[`FFMD_CFG_Y_EN];
   assign x_axis_enable = detect_config_reg[`FFMD_CFG_X_EN];
   assign any_enable = z_axis_enable | y_axis_enable | x_axis_enable;

   // ------------------------------------------------------------
   // Axis comparisons
   // ------------------------------------------------------------
   // Samples are signed, already scaled to threshold units
   ffmd_axis_cmp u_cmp_x
   (
      .i_sample(i_x_sample),
      .i_threshold(i_detect_threshold),
      .o_over(x_over),
      .o_under(x_under),
      .o_negative(x_neg)
   );

   ffmd_axis_cmp u_cmp_y
   (
      .i_sample(i_y_sample),
      .i_threshold(i_detect_threshold),
      .o_over(y_over),
      .o_under(y_under),
      .o_negative(y_neg)
   );

   ffmd_axis_cmp u_cmp_z
   (
      .i_sample(i_z_sample),
      .i_threshold(i_detect_threshold),
      .o_over(z_over),
      .o_under(z_under),
      .o_negative(z_neg)
   );

   // Disabled axes do not veto freefall and never raise motion
   assign motion_cond = (x_axis_enable & x_over) | (y_axis_enable & y_over)
      | (z_axis_enable & z_over);
   assign freefall_cond = (~x_axis_enable | x_under)
      & (~y_axis_enable | y_under) & (~z_axis_enable | z_under);
   assign condition = any_enable
      & (or_and_select ? motion_cond : freefall_cond);

   // Raw high-g flags, sign only set with its axis flag
   assign live_flags = {z_over, z_over & z_neg, y_over, y_over & y_neg,
      x_over, x_over & x_neg};
   assign enable_mask = {z_axis_enable, z_axis_enable, y_axis_enable,
      y_axis_enable, x_axis_enable, x_axis_enable};

   // ------------------------------------------------------------
   // Register access
   // ------------------------------------------------------------
   assign src_hit = ffmd_addr_hit(i_reg_addr, `FFMD_ADDR_SOURCE);
   assign cfg_hit = ffmd_addr_hit(i_reg_addr, `FFMD_ADDR_CONFIG);
   assign src_read = i_reg_rd & src_hit;
   assign cfg_write = i_reg_wr & cfg_hit;

   // ------------------------------------------------------------
   // Source register view
   // ------------------------------------------------------------
   // Masking at the read port keeps disabled axes at zero
   assign detect_source_reg = {event_active, 1'b0,
      axis_flags & enable_mask};

   // A latched read restarts the debounce from zero
   assign base_count = (latch_events & src_read) ? `FFMD_COUNT_RESET
      : debounce_count;

   // ------------------------------------------------------------
   // Debounce and event logic
   // ------------------------------------------------------------
   always @*
   begin
      next_count = base_count;
      next_active = event_active;
      next_flags = axis_flags;
      if (latch_events & src_read)
      begin
         next_active = 1'b0;
         next_flags = `FFMD_FLAGS_RESET;
      end
      if (i_sample_valid)
      begin
         if (condition)
         begin
            // Never counts past the target
            if (base_count < i_debounce_target)
            begin
               next_count = base_count + `FFMD_COUNT_ONE;
            end
         end
         else if (i_debounce_lapse_mode)
         begin
            next_count = `FFMD_COUNT_RESET;
         end
         else
         begin
            next_count = ffmd_step_down(base_count);
         end
         if (condition && (next_count == i_debounce_target))
         begin
            // Set beats a clearing read in the same cycle
            next_active = 1'b1;
         end
         else if (!latch_events && !condition
            && (next_count == `FFMD_COUNT_RESET))
         begin
            next_active = 1'b0;
         end
         // Frozen once latched and active
         if (!(latch_events && event_active && !src_read))
         begin
            next_flags = live_flags;
         end
      end
      if (!any_enable)
      begin
         next_count = `FFMD_COUNT_RESET;
         next_active = 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Interrupt routing
   // ------------------------------------------------------------
   // Route high selects line 1, low selects line 2
   // Taken from the next flag so the lines change with the event bit
   assign next_irq1 = next_active & i_detect_irq_enable
      & i_detect_irq_route;
   assign next_irq2 = next_active & i_detect_irq_enable
      & ~i_detect_irq_route;

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always @(posedge i_clk)
   begin
      if (!i_reset_n)
      begin
         detect_config_reg <= `FFMD_CONFIG_RESET;
         event_active <= 1'b0;
         axis_flags <= `FFMD_FLAGS_RESET;
         debounce_count <= `FFMD_COUNT_RESET;
         o_reg_rdata <= `FFMD_RDATA_UNMAPPED;
         o_event_active <= 1'b0;
         o_irq_line1 <= 1'b0;
         o_irq_line2 <= 1'b0;
      end
      else
      begin
         if (cfg_write)
         begin
            // Low three bits are not stored and read zero
            detect_config_reg <= i_reg_wdata
               & `FFMD_CFG_STORED_MASK;
         end
         event_active <= next_active;
         axis_flags <= next_flags;
         debounce_count <= next_count;
         if (i_reg_rd)
         begin
            case (i_reg_addr)
               `FFMD_ADDR_CONFIG:
               begin
                  o_reg_rdata <= detect_config_reg;
               end
               `FFMD_ADDR_SOURCE:
               begin
                  // Captures the value before the read clears it
                  o_reg_rdata <= detect_source_reg;
               end
               default:
               begin
                  // Unmapped offsets read as zero
                  o_reg_rdata <= `FFMD_RDATA_UNMAPPED;
               end
            endcase
         end
         o_event_active <= next_active;
         o_irq_line1 <= next_irq1;
         o_irq_line2 <= next_irq2;
      end
   end

endmodule // ffmd_detector

`default_nettype wire
